//--- rtl/tac_defs.vh
// Constants for the timer 3 auto-reload counter.
`ifndef TAC_DEFS_VH
`define TAC_DEFS_VH
// ----------------------------------------
// Register offsets and reset values
// ----------------------------------------
`define TAC_ADDR_CONTROL   8'h91
`define TAC_ADDR_COUNT_LO  8'h94
`define TAC_ADDR_COUNT_HI  8'h95
`define TAC_ADDR_RELOAD_LO 8'h92
`define TAC_ADDR_RELOAD_HI 8'h93
`define TAC_CONTROL_RESET  8'h00
// ----------------------------------------
// Control field positions
// ----------------------------------------
`define TAC_BIT_HIGH_FLAG  7
`define TAC_BIT_LOW_FLAG   6
`define TAC_BIT_LOW_IRQEN  5
`define TAC_BIT_CAPTURE    4
`define TAC_BIT_SPLIT      3
`define TAC_BIT_RUN        2
// ----------------------------------------
// Clock source codes and divider counts
// ----------------------------------------
`define TAC_SEL_SYSDIV     2'h0
`define TAC_SEL_EXTDIV     2'h1
`define TAC_SEL_LFODIV     2'h3
`define TAC_DIV_SYS        4'hc
`define TAC_DIV_EXT        4'h8
`endif

//--- rtl/tac_divider.v
// Edge-counting divider that turns a source into a one-cycle tick.
`timescale 1ns/1ps
module tac_divider (
	input  wire       mclk,
	input  wire       rst_n,
	input  wire       src_edge,
	input  wire [3:0] divide_by,
	output reg        tick
);
	reg [3:0] count_reg;

	// ----------------------------------------
	// Counter
	// ----------------------------------------
	// Counts source edges and pulses once every divide_by edges.
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			count_reg <= 4'h0;
			tick      <= 1'b0;
		end else begin
			tick <= 1'b0;
			if (src_edge) begin
				if (count_reg >= divide_by - 4'h1) begin
					count_reg <= 4'h0;
					tick      <= 1'b1;
				end else begin
					count_reg <= count_reg + 4'h1;
				end
			end
		end
	end
endmodule

//--- rtl/tac_timer.v
// Timer 3: 16-bit or split 8-bit auto-reload counter with control register.
`timescale 1ns/1ps
`include "tac_defs.vh"
module tac_timer (
	input  wire       mclk,
	input  wire       rst_n,
	input  wire [7:0] sfr_addr,
	input  wire [7:0] sfr_wdata,
	input  wire       sfr_wr,
	input  wire       sfr_rd,
	input  wire       ext_clk_in,
	input  wire       slow_osc_in,
	input  wire       timer_irq_enable,
	input  wire       high_byte_clock_select,
	input  wire       low_byte_clock_select,
	output reg  [7:0] sfr_rdata,
	output reg        timer_irq,
	output reg  [7:0] count_high_byte,
	output reg  [7:0] count_low_byte
);
	reg [7:0] control_reg;
	reg [7:0] reload_high_byte;
	reg [7:0] reload_low_byte;
	reg       ext_meta_reg;
	reg       ext_sync_reg;
	reg       ext_prev_reg;
	reg       osc_meta_reg;
	reg       osc_sync_reg;
	reg       osc_prev_reg;
	reg [3:0] div_ratio;
	reg       div_src;
	reg       ext_tick_sel;
	reg       low_tick;
	reg       high_tick;
	reg       low_roll;
	reg       high_roll;
	reg       capture_event;
	reg [7:0] control_next;
	wire      ext_tick;
	wire      split_mode_enable;
	wire      run_control;
	wire      osc_capture_enable;
	wire      low_byte_irq_enable;
	wire [1:0] ext_clock_select;
	wire      ext_rise;
	wire      osc_rise;
	wire      osc_fall;

	assign split_mode_enable   = control_reg[`TAC_BIT_SPLIT];
	assign run_control         = control_reg[`TAC_BIT_RUN];
	assign osc_capture_enable  = control_reg[`TAC_BIT_CAPTURE];
	assign low_byte_irq_enable = control_reg[`TAC_BIT_LOW_IRQEN];
	assign ext_clock_select    = control_reg[1:0];
	assign ext_rise = ext_sync_reg & ~ext_prev_reg;
	assign osc_rise = osc_sync_reg & ~osc_prev_reg;
	assign osc_fall = ~osc_sync_reg & osc_prev_reg;

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	// Two flops per asynchronous source; edges are found past the second stage only.
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ext_meta_reg <= 1'b0;
			ext_sync_reg <= 1'b0;
			ext_prev_reg <= 1'b0;
			osc_meta_reg <= 1'b0;
			osc_sync_reg <= 1'b0;
			osc_prev_reg <= 1'b0;
		end else begin
			ext_meta_reg <= ext_clk_in;
			ext_sync_reg <= ext_meta_reg;
			ext_prev_reg <= ext_sync_reg;
			osc_meta_reg <= slow_osc_in;
			osc_sync_reg <= osc_meta_reg;
			osc_prev_reg <= osc_sync_reg;
		end
	end

	// ----------------------------------------
	// Clock source selection
	// ----------------------------------------
	// The reserved code counts nothing, so a stray write cannot run the timer.
	always @* begin
		div_src   = 1'b0;
		div_ratio = `TAC_DIV_EXT;
		case (ext_clock_select)
			`TAC_SEL_SYSDIV: begin
				div_src   = 1'b1;
				div_ratio = `TAC_DIV_SYS;
			end
			`TAC_SEL_EXTDIV: div_src = ext_rise;
			`TAC_SEL_LFODIV: div_src = osc_rise;
			default:         div_src = 1'b0;
		endcase
	end

	// One shared divider serves both bytes in split mode.
	tac_divider u_ext_div (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.src_edge  (div_src),
		.divide_by (div_ratio),
		.tick      (ext_tick)
	);

	// ----------------------------------------
	// Count enables
	// ----------------------------------------
	// Per-byte select 1 takes the system clock, 0 takes the selected source; the high byte select acts in split mode only.
	always @* begin
		ext_tick_sel = ext_tick;
		low_tick  = low_byte_clock_select ? 1'b1 : ext_tick_sel;
		high_tick = high_byte_clock_select ? 1'b1 : ext_tick_sel;
		if (split_mode_enable) begin
			high_tick = high_tick & run_control;
		end else begin
			low_tick  = low_tick & run_control;
			high_tick = 1'b0;
		end
		low_roll  = low_tick & (count_low_byte == 8'hff);
		if (split_mode_enable)
			high_roll = high_tick & (count_high_byte == 8'hff);
		else
			high_roll = low_roll & (count_high_byte == 8'hff);
		capture_event = osc_capture_enable & osc_fall;
	end

	// ----------------------------------------
	// Counter and reload registers
	// ----------------------------------------
	// A software write to the reload bytes loses to a capture in the same cycle.
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			count_low_byte   <= 8'h00;
			count_high_byte  <= 8'h00;
			reload_low_byte  <= 8'h00;
			reload_high_byte <= 8'h00;
		end else begin
			if (sfr_wr && sfr_addr == `TAC_ADDR_RELOAD_LO)
				reload_low_byte <= sfr_wdata;
			if (sfr_wr && sfr_addr == `TAC_ADDR_RELOAD_HI)
				reload_high_byte <= sfr_wdata;
			if (capture_event) begin
				reload_low_byte  <= count_low_byte;
				reload_high_byte <= count_high_byte;
			end
			if (sfr_wr && sfr_addr == `TAC_ADDR_COUNT_LO)
				count_low_byte <= sfr_wdata;
			else if (low_roll && split_mode_enable)
				count_low_byte <= reload_low_byte;
			else if (high_roll && !split_mode_enable)
				count_low_byte <= reload_low_byte;
			else if (low_tick)
				count_low_byte <= count_low_byte + 8'h01;
			if (sfr_wr && sfr_addr == `TAC_ADDR_COUNT_HI)
				count_high_byte <= sfr_wdata;
			else if (high_roll)
				count_high_byte <= reload_high_byte;
			else if (split_mode_enable ? high_tick : low_roll)
				count_high_byte <= count_high_byte + 8'h01;
		end
	end

	// ----------------------------------------
	// Control register and flags
	// ----------------------------------------
	// Hardware sets win over a software clear in the same cycle.
	always @* begin
		control_next = control_reg;
		if (sfr_wr && sfr_addr == `TAC_ADDR_CONTROL)
			control_next = sfr_wdata;
		if (high_roll)
			control_next[`TAC_BIT_HIGH_FLAG] = 1'b1;
		if (low_roll)
			control_next[`TAC_BIT_LOW_FLAG] = 1'b1;
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			control_reg <= `TAC_CONTROL_RESET;
		else
			control_reg <= control_next;
	end

	// ----------------------------------------
	// Interrupt request and read data
	// ----------------------------------------
	// The request is a level while the high flag, or the low flag with its enable, stands; capture adds a one-cycle pulse.
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			timer_irq <= 1'b0;
			sfr_rdata <= 8'h00;
		end else begin
			timer_irq <= timer_irq_enable &
				(control_next[`TAC_BIT_HIGH_FLAG] |
				(control_next[`TAC_BIT_LOW_FLAG] & control_next[`TAC_BIT_LOW_IRQEN]) |
				capture_event);
			if (sfr_rd) begin
				case (sfr_addr)
					`TAC_ADDR_CONTROL:   sfr_rdata <= control_reg;
					`TAC_ADDR_RELOAD_LO: sfr_rdata <= reload_low_byte;
					`TAC_ADDR_RELOAD_HI: sfr_rdata <= reload_high_byte;
					`TAC_ADDR_COUNT_LO:  sfr_rdata <= count_low_byte;
					`TAC_ADDR_COUNT_HI:  sfr_rdata <= count_high_byte;
					default:             sfr_rdata <= 8'h00;
				endcase
			end
		end
	end
endmodule

//--- bench/tac_timer_asserts.sv
// Port checker for the timer 3 counter.
`timescale 1ns/1ps
`include "tac_defs.vh"
module tac_timer_asserts (
	input wire       mclk,
	input wire       rst_n,
	input wire [7:0] sfr_addr,
	input wire [7:0] sfr_wdata,
	input wire       sfr_wr,
	input wire       sfr_rd,
	input wire       timer_irq_enable,
	input wire [7:0] sfr_rdata,
	input wire       timer_irq,
	input wire [7:0] count_high_byte,
	input wire [7:0] count_low_byte
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// --------------------------------
	// Bus and counting relations
	// --------------------------------
	// Reads of unmapped places must not leak stale data.
	a_unmapped_read_zero: assert property (sfr_rd && (sfr_addr < 8'h91 || sfr_addr > 8'h95) ##1 !sfr_rd
		|=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
	a_rdata_holds: assert property (!sfr_rd [*2] |=> $stable(sfr_rdata)) else $error("read data moved");
	a_count_write_lo: assert property (sfr_wr && sfr_addr == `TAC_ADDR_COUNT_LO
		|=> count_low_byte == $past(sfr_wdata)) else $error("low count write lost");
	a_count_write_hi: assert property (sfr_wr && sfr_addr == `TAC_ADDR_COUNT_HI
		|=> count_high_byte == $past(sfr_wdata)) else $error("high count write lost");
	a_irq_needs_enable: assert property (!timer_irq_enable [*2] |-> !timer_irq)
		else $error("interrupt while disabled");
	a_low_count_step: assert property ($past(count_low_byte) != 8'hff && !$past(sfr_wr) && $changed(count_low_byte)
		|-> count_low_byte == $past(count_low_byte) + 8'h01) else $error("low byte bad step");
	a_high_count_step: assert property ($past(count_high_byte) != 8'hff && !$past(sfr_wr) && $changed(count_high_byte)
		|-> count_high_byte == $past(count_high_byte) + 8'h01) else $error("high byte bad step");
	a_reset_outputs: assert property ($rose(rst_n) |-> count_high_byte == 8'h00 && count_low_byte == 8'h00
		&& !timer_irq) else $error("outputs not clear after reset");
	c_low_roll: cover property ($past(count_low_byte) == 8'hff && count_low_byte != 8'hff);
	c_irq_rise: cover property ($rose(timer_irq));
	c_ctl_read: cover property (sfr_rd && sfr_addr == `TAC_ADDR_CONTROL);
endmodule
bind tac_timer tac_timer_asserts u_chk (.mclk, .rst_n, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .timer_irq_enable,
	.sfr_rdata, .timer_irq, .count_high_byte, .count_low_byte);

//--- bench/tac_timer_test.sv
// Self-checking testbench for the timer 3 counter.
`timescale 1ns/1ps
`include "tac_defs.vh"
module tac_timer_test;
	logic       mclk, rst_n, sfr_wr, sfr_rd, ext_clk_in, slow_osc_in, timer_irq_enable, tgl;
	logic       high_byte_clock_select, low_byte_clock_select, timer_irq;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, count_high_byte, count_low_byte, rv;
	int         num_errors, check_count, i, n, m_rel, m_cnt;
	int         m_lo, m_hi;
	int         exp_q [$];
	int         exp_ticks [4] = '{16, 12, 0, 12};
	tac_timer dut (.mclk, .rst_n, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .ext_clk_in, .slow_osc_in,
		.timer_irq_enable, .high_byte_clock_select, .low_byte_clock_select, .sfr_rdata, .timer_irq,
		.count_high_byte, .count_low_byte);
	// --------------------------------
	// Shared tasks
	// --------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Reference model: one tick of a counter portion of the given span, reloading on overflow.
	function automatic int mdl_step(input int cnt, input int rel, input int span);
		return (cnt == span - 1) ? rel : cnt + 1;
	endfunction
	// Every step lands 1 ns after the edge, so inputs never race the sampling edge.
	task automatic cyc(input int k);
		repeat (k) begin
			@(posedge mclk);
			#1;
			if (tgl) begin
				ext_clk_in = ~ext_clk_in;
				slow_osc_in = ~slow_osc_in;
			end
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		cyc(1);
		sfr_wr = 1'b0;
		// An idle edge keeps the strobe from being lowered and raised in one step.
		cyc(1);
	endtask
	task automatic rd(input logic [7:0] a);
		sfr_addr = a;
		sfr_rd = 1'b1;
		cyc(1);
		sfr_rd = 1'b0;
		cyc(1);
		rv = sfr_rdata;
	endtask
	task automatic put16(input logic [7:0] ah, input int v);
		wr(ah, v[15:8]);
		wr(ah - 8'h01, v[7:0]);
	endtask
	task automatic tick_low;
		low_byte_clock_select = 1'b1;
		cyc(1);
		low_byte_clock_select = 1'b0;
		cyc(2);
	endtask
	task automatic complete_run;
		$display("Checks %0d, mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// --------------------------------
	// Clock, watchdog and tests
	// --------------------------------
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// The tests take about 1000 cycles; twenty times that means a hang.
	initial begin
		#200000;
		num_errors++;
		complete_run;
	end
	initial begin
		{sfr_wr, sfr_rd, ext_clk_in, slow_osc_in, tgl, high_byte_clock_select, low_byte_clock_select} = '0;
		{sfr_addr, sfr_wdata, num_errors, check_count, rst_n} = '0;
		timer_irq_enable = 1'b1;
		i = $urandom(36579);
		repeat (4) @(posedge mclk);
		#1 rst_n = 1'b1;
		rd(`TAC_ADDR_CONTROL);
		chk(rv, `TAC_CONTROL_RESET);
		rd(8'h90);
		chk(rv, 8'h00);
		$display("Test reset done");
		// Reserved source gives no ticks, so single ticks come from the low select.
		m_rel = $urandom;
		wr(`TAC_ADDR_CONTROL, 8'h06);
		put16(`TAC_ADDR_RELOAD_HI, m_rel);
		put16(`TAC_ADDR_COUNT_HI, 16'hffff);
		cyc(20);
		chk({count_high_byte, count_low_byte}, 16'hffff);
		exp_q.push_back(mdl_step(16'hffff, m_rel[15:0], 65536));
		tick_low;
		chk({count_high_byte, count_low_byte}, exp_q.pop_front());
		chk(timer_irq, 1'b1);
		timer_irq_enable = 1'b0;
		cyc(30);
		chk(timer_irq, 1'b0);
		timer_irq_enable = 1'b1;
		rd(`TAC_ADDR_CONTROL);
		chk(rv, 8'hc6);
		wr(`TAC_ADDR_CONTROL, 8'h06);
		cyc(2);
		chk(timer_irq, 1'b0);
		$display("Test rollover done");
		// Split mode: the run bit gates only the high byte.
		for (i = 0; i < 2; i++) begin
			wr(`TAC_ADDR_CONTROL, i ? 8'h0e : 8'h0a);
			put16(`TAC_ADDR_COUNT_HI, 0);
			n = $urandom_range(40, 5);
			{high_byte_clock_select, low_byte_clock_select} = 2'b11;
			cyc(n);
			{high_byte_clock_select, low_byte_clock_select} = 2'b00;
			cyc(1);
			m_lo = 0;
			m_hi = 0;
			repeat (n) begin
				m_lo = mdl_step(m_lo, 0, 256);
				if (i)
					m_hi = mdl_step(m_hi, 0, 256);
			end
			exp_q.push_back(m_hi * 256 + m_lo);
			chk({count_high_byte, count_low_byte}, exp_q.pop_front());
			wr(`TAC_ADDR_COUNT_LO, 8'hff);
			wr(`TAC_ADDR_CONTROL, i ? 8'h2a : 8'h0a);
			tick_low;
			chk(count_low_byte, mdl_step(8'hff, m_rel[7:0], 256));
			chk(timer_irq, i[0]);
			rd(`TAC_ADDR_CONTROL);
			chk(rv, i ? 8'h6a : 8'h4a);
		end
		$display("Test split done");
		// Every source code, with both source pins toggling each cycle.
		tgl = 1'b1;
		for (i = 0; i < 4; i++) begin
			wr(`TAC_ADDR_CONTROL, 8'h04 | i[7:0]);
			put16(`TAC_ADDR_COUNT_HI, 0);
			cyc(192);
			wr(`TAC_ADDR_CONTROL, 8'h06);
			n = count_low_byte;
			chk(n >= exp_ticks[i] - 1 && n <= exp_ticks[i] + 1, 1'b1);
		end
		tgl = 1'b0;
		$display("Test sources done");
		// A falling oscillator edge copies the count into the reload pair.
		wr(`TAC_ADDR_CONTROL, 8'h16);
		m_cnt = $urandom;
		put16(`TAC_ADDR_COUNT_HI, m_cnt);
		slow_osc_in = 1'b1;
		cyc(6);
		slow_osc_in = 1'b0;
		cyc(3);
		chk(timer_irq, 1'b1);
		cyc(1);
		chk(timer_irq, 1'b0);
		cyc(2);
		rd(`TAC_ADDR_RELOAD_HI);
		chk(rv, m_cnt[15:8]);
		rd(`TAC_ADDR_RELOAD_LO);
		chk(rv, m_cnt[7:0]);
		$display("Test capture done");
		complete_run;
	end
endmodule
